/* File: rtl/tcpt_pkg.sv */
// Package for the two-channel capture/compare/PWM timer.
// Assumes a 32-bit AXI4-Lite register bus, word aligned.
package tcpt_pkg;
	localparam int TCPT_AW = 6;
	localparam logic [5:0] TCPT_OFS_CTRL = 6'h00;
	localparam logic [5:0] TCPT_OFS_CNT = 6'h04;
	localparam logic [5:0] TCPT_OFS_MOD = 6'h08;
	localparam logic [5:0] TCPT_OFS_CH0C = 6'h0C;
	localparam logic [5:0] TCPT_OFS_CH0V = 6'h10;
	localparam logic [5:0] TCPT_OFS_CH1C = 6'h14;
	localparam logic [5:0] TCPT_OFS_CH1V = 6'h18;
	localparam logic [5:0] TCPT_OFS_BFC = 6'h1C;
	// Timer control/status fields
	localparam int TCPT_CT_PS = 0;
	localparam int TCPT_CT_RST = 4;
	localparam int TCPT_CT_STOP = 5;
	localparam int TCPT_CT_OIE = 6;
	localparam int TCPT_CT_OVF = 7;
	// Channel control fields
	localparam int TCPT_CC_MAX = 0;
	localparam int TCPT_CC_TOV = 1;
	localparam int TCPT_CC_ELA = 2;
	localparam int TCPT_CC_ELB = 3;
	localparam int TCPT_CC_MSA = 4;
	localparam int TCPT_CC_MSB = 5;
	localparam int TCPT_CC_IE = 6;
	localparam int TCPT_CC_FLG = 7;
	localparam int TCPT_BF_BCE = 7;
	localparam logic [7:0] TCPT_CTRL_RST = 8'h20;
	localparam logic [7:0] TCPT_CH_RST = 8'h00;
	localparam logic [15:0] TCPT_MOD_RST = 16'hFFFF;
	localparam logic [7:0] TCPT_BFC_RST = 8'h00;
	localparam logic [2:0] TCPT_PS_EXT = 3'h7;
	localparam logic [1:0] TCPT_RESP_OK = 2'h0;
	localparam logic [1:0] TCPT_RESP_ERR = 2'h2;
endpackage

/* File: rtl/tcpt_timer.sv */
// Two-channel 16-bit timer with capture, compare, PWM and buffered link.
// Assumes pins synchronous to aclk; break input from the system unit.
//
// Contract
// - Two independent capture/compare channels, shared counter
// - 16-bit up-counter, free-running or modulo limited
// - Counter reads never disturb counting
// - Three-bit divide select picks clock rate
// - Capture counter on programmed pin edge
// - Capture event can raise enabled interrupt
// - Compare match sets, clears or toggles pin
// - Compare match can raise enabled interrupt
// - Unbuffered value writes take effect immediately
// - Link select bit joins channels onto pin zero
// - Last written set takes over at overflow
// - Linked: channel one control unused, pin released
// - Toggle-on-overflow toggles pin at modulo, sets it high when the max bit is set
// - PWM period is modulo plus one counts
// - Break clear enable gates flag clearing
// - Overflow flag: read-then-write-zero clear
// - Channel flag sets on event, irq if enabled
// - Divide select all ones picks external clock
// - Break state stops the counter
`timescale 1ns/1ps
`default_nettype none
module tcpt_timer
	import tcpt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tcpt_pkg::TCPT_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tcpt_pkg::TCPT_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_count_clock,
	input wire logic break_state,
	input wire logic [1:0] channel_pin_in,
	output logic [1:0] channel_pin_out,
	output logic [1:0] channel_pin_oe,
	output logic timer_irq
);
	import tcpt_pkg::*;

	logic [7:0] ctrl_r;
	logic [15:0] cnt_r;
	logic [15:0] mod_r;
	logic [7:0] chc_r [2];
	logic [15:0] chv_r [2];
	logic [7:0] bfc_r;
	logic [6:0] pre_r;
	logic ext_d_r;
	logic [1:0] pin_d_r;
	logic [1:0] pout_r;
	logic ovf_armed_r;
	logic act_r;
	logic pend_r;
	logic pend_set_r;
	logic tick;
	logic at_mod;
	logic ovf_ev;
	logic [1:0] ch_ev;
	logic clr_ok;

	// AXI write/read capture
	logic aw_have_r, w_have_r;
	logic [5:0] aw_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic wr_go;
	logic rd_go;
	logic wmap;
	logic rmap;

	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wmap = (aw_r <= TCPT_OFS_BFC) && (aw_r[1:0] == 2'h0);
	assign rmap = (s_axi_araddr <= TCPT_OFS_BFC) && (s_axi_araddr[1:0] == 2'h0);
	assign clr_ok = !break_state || bfc_r[TCPT_BF_BCE];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_r <= 6'h00;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= TCPT_RESP_OK;
		end
		else
		begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				aw_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wmap ? TCPT_RESP_OK : TCPT_RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	logic [31:0] rd_val;
	always_comb
	begin
		rd_val = 32'h0;
		case (s_axi_araddr)
			TCPT_OFS_CTRL: rd_val = {24'h0, ctrl_r};
			TCPT_OFS_CNT: rd_val = {16'h0, cnt_r};
			TCPT_OFS_MOD: rd_val = {16'h0, mod_r};
			TCPT_OFS_CH0C: rd_val = {24'h0, chc_r[0]};
			TCPT_OFS_CH0V: rd_val = {16'h0, chv_r[0]};
			TCPT_OFS_CH1C: rd_val = {24'h0, chc_r[1]};
			TCPT_OFS_CH1V: rd_val = {16'h0, chv_r[1]};
			TCPT_OFS_BFC: rd_val = {24'h0, bfc_r};
			default: rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= TCPT_RESP_OK;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rmap ? TCPT_RESP_OK : TCPT_RESP_ERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	wire wr_ctrl = wr_go && aw_r == TCPT_OFS_CTRL && ws_r[0];
	wire wr_mod = wr_go && aw_r == TCPT_OFS_MOD;
	wire wr_bfc = wr_go && aw_r == TCPT_OFS_BFC && ws_r[0];
	wire linked = chc_r[0][TCPT_CC_MSB];

	// Prescaler and clock source
	logic [2:0] ps;
	assign ps = ctrl_r[TCPT_CT_PS +: 3];
	always_ff @(posedge aclk)
	begin
		if (!aresetn || ctrl_r[TCPT_CT_RST])
			pre_r <= 7'h00;
		else if (!ctrl_r[TCPT_CT_STOP] && !break_state)
			pre_r <= pre_r + 7'h01;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_d_r <= 1'b0;
		else
			ext_d_r <= external_count_clock;
	end
	always_comb
	begin
		if (ps == TCPT_PS_EXT)
			tick = external_count_clock && !ext_d_r;
		else if (ps == 3'h0)
			tick = 1'b1;
		else
			tick = (pre_r & ((7'h01 << ps) - 7'h01)) == ((7'h01 << ps) - 7'h01);
		if (ctrl_r[TCPT_CT_STOP] || break_state)
			tick = 1'b0;
	end

	// Counter
	assign at_mod = cnt_r == mod_r;
	assign ovf_ev = tick && at_mod;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || ctrl_r[TCPT_CT_RST])
			cnt_r <= 16'h0000;
		else if (ovf_ev)
			cnt_r <= 16'h0000;
		else if (tick)
			cnt_r <= cnt_r + 16'h0001;
	end

	// Timer control, overflow flag with two-step clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= TCPT_CTRL_RST;
			ovf_armed_r <= 1'b0;
		end
		else
		begin
			if (rd_go && s_axi_araddr == TCPT_OFS_CTRL && ctrl_r[TCPT_CT_OVF])
				ovf_armed_r <= 1'b1;
			if (wr_ctrl)
			begin
				ctrl_r[6:0] <= wd_r[6:0];
				ctrl_r[3] <= 1'b0;
			end
			else
				ctrl_r[TCPT_CT_RST] <= 1'b0;
			if (ovf_ev)
			begin
				ctrl_r[TCPT_CT_OVF] <= 1'b1;
				ovf_armed_r <= 1'b0;
			end
			else if (wr_ctrl && !wd_r[TCPT_CT_OVF] && ovf_armed_r && clr_ok)
			begin
				ctrl_r[TCPT_CT_OVF] <= 1'b0;
				ovf_armed_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mod_r <= TCPT_MOD_RST;
			bfc_r <= TCPT_BFC_RST;
		end
		else
		begin
			if (wr_mod && ws_r[0])
				mod_r[7:0] <= wd_r[7:0];
			if (wr_mod && ws_r[1])
				mod_r[15:8] <= wd_r[15:8];
			if (wr_bfc)
				bfc_r <= {wd_r[TCPT_BF_BCE], 7'h00};
		end
	end

	// Active set for linked mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !linked)
		begin
			act_r <= 1'b0;
			pend_r <= 1'b0;
			pend_set_r <= 1'b0;
		end
		else
		begin
			if (wr_go && (aw_r == TCPT_OFS_CH0V || aw_r == TCPT_OFS_CH1V))
			begin
				pend_r <= 1'b1;
				pend_set_r <= aw_r == TCPT_OFS_CH1V;
			end
			if (ovf_ev && pend_r)
			begin
				act_r <= pend_set_r;
				pend_r <= 1'b0;
			end
		end
	end

	// Channels
	logic [1:0] irq_ch;
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_ch
			localparam logic [5:0] OFS_C = g ? TCPT_OFS_CH1C : TCPT_OFS_CH0C;
			localparam logic [5:0] OFS_V = g ? TCPT_OFS_CH1V : TCPT_OFS_CH0V;
			logic armed_r;
			logic [7:0] cc;
			logic is_out;
			logic rise, fall, cap, match, use_ch;
			assign cc = chc_r[0][TCPT_CC_MSB] ? chc_r[0] : chc_r[g];
			assign is_out = cc[TCPT_CC_MSA] || cc[TCPT_CC_MSB];
			assign rise = channel_pin_in[g] && !pin_d_r[g];
			assign fall = !channel_pin_in[g] && pin_d_r[g];
			assign cap = !is_out && !(g == 1 && linked) && ((rise && cc[TCPT_CC_ELA]) || (fall && cc[TCPT_CC_ELB]));
			assign use_ch = (g == 0) || !linked;
			assign match = use_ch && tick && is_out && cnt_r == chv_r[(g == 0 && linked) ? act_r : 1'(g)];
			assign ch_ev[g] = cap || match;
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					pin_d_r[g] <= 1'b0;
				else
					pin_d_r[g] <= channel_pin_in[g];
			end
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					chc_r[g] <= TCPT_CH_RST;
					chv_r[g] <= 16'h0000;
					armed_r <= 1'b0;
				end
				else
				begin
					if (rd_go && s_axi_araddr == OFS_C && chc_r[g][TCPT_CC_FLG])
						armed_r <= 1'b1;
					if (wr_go && aw_r == OFS_C && ws_r[0])
						chc_r[g][6:0] <= wd_r[6:0];
					if (cap)
						chv_r[g] <= cnt_r;
					else if (wr_go && aw_r == OFS_V)
					begin
						if (ws_r[0])
							chv_r[g][7:0] <= wd_r[7:0];
						if (ws_r[1])
							chv_r[g][15:8] <= wd_r[15:8];
					end
					if (ch_ev[g])
					begin
						chc_r[g][TCPT_CC_FLG] <= 1'b1;
						armed_r <= 1'b0;
					end
					else if (wr_go && aw_r == OFS_C && ws_r[0] && !wd_r[TCPT_CC_FLG] && armed_r && clr_ok)
					begin
						chc_r[g][TCPT_CC_FLG] <= 1'b0;
						armed_r <= 1'b0;
					end
				end
			end
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pout_r[g] <= 1'b0;
					channel_pin_oe[g] <= 1'b0;
				end
				else
				begin
					channel_pin_oe[g] <= is_out && !(g == 1 && linked);
					if (match && cc[TCPT_CC_ELB] && cc[TCPT_CC_ELA])
						pout_r[g] <= 1'b1;
					else if (match && cc[TCPT_CC_ELB])
						pout_r[g] <= 1'b0;
					else if (match && cc[TCPT_CC_ELA])
						pout_r[g] <= !pout_r[g];
					else if (ovf_ev && use_ch && is_out && cc[TCPT_CC_TOV])
						pout_r[g] <= cc[TCPT_CC_MAX] ? 1'b1 : !pout_r[g];
				end
			end
			assign irq_ch[g] = chc_r[g][TCPT_CC_FLG] && chc_r[g][TCPT_CC_IE];
		end
	endgenerate
	assign channel_pin_out = pout_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= (ctrl_r[TCPT_CT_OVF] && ctrl_r[TCPT_CT_OIE]) || (|irq_ch);
	end
endmodule // tcpt_timer
`default_nettype wire

/* File: verification/tb.sv */
// Testbench for the capture/compare/PWM timer.
// Assumes checker and pin model compiled before.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tcpt_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic external_count_clock, break_state, timer_irq, ext_run, arm, p0;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, channel_pin_in, channel_pin_out, channel_pin_oe, drive;
	logic [15:0] v;
	logic [65:0] x;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	logic [31:0] pq[$];
	int num_errors = 0, cmp_count = 0, cyc = 0, last = 0;
	tcpt_timer dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.external_count_clock(external_count_clock), .break_state(break_state),
		.channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
		.channel_pin_oe(channel_pin_oe), .timer_irq(timer_irq));
	tcpt_pin_model u_pins (
		.aclk(aclk), .drive(drive), .ext_run(ext_run), .channel_pin_out(channel_pin_out),
		.channel_pin_oe(channel_pin_oe), .channel_pin_in(channel_pin_in),
		.external_count_clock(external_count_clock));
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r = TCPT_RESP_OK);
		logic pa = 1'b1;
		logic pw = 1'b1;
		@(posedge aclk);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end while (pa || pw || !s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1,
		input logic [1:0] r = TCPT_RESP_OK);
		logic pa = 1'b1;
		@(posedge aclk);
		rq.push_back({r, m, e & m});
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			pa = pa && !s_axi_arready;
			s_axi_arvalid <= pa;
		end while (pa || !s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	task automatic meas(input int e);
		pq = {32'(e)};
		last = 0;
		arm = 1'b1;
		repeat (2000) if (arm) @(posedge aclk);
		chk(32'(arm), 32'h0);
	endtask
	// Result watcher: responses and pin period
	always @(posedge aclk)
	begin
		cyc++;
		if (s_axi_bvalid && s_axi_bready)
			chk(32'(s_axi_bresp), 32'(bq.pop_front()));
		if (s_axi_rvalid && s_axi_rready)
		begin
			x = rq.pop_front();
			chk(s_axi_rdata & x[63:32], x[31:0]);
			chk(32'(s_axi_rresp), 32'(x[65:64]));
		end
		if (arm && channel_pin_out[0] && !p0)
		begin
			if (last > 0)
			begin
				chk(32'(cyc - last), pq.pop_front());
				arm = 1'b0;
			end
			last = cyc;
		end
		p0 = channel_pin_out[0];
	end
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{aresetn, break_state, ext_run, arm, p0, drive, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(32'ha836));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(TCPT_OFS_CTRL, 32'(TCPT_CTRL_RST));
		rd(TCPT_OFS_CNT, 32'h0);
		rd(TCPT_OFS_MOD, 32'(TCPT_MOD_RST));
		rd(TCPT_OFS_CH1C, 32'(TCPT_CH_RST));
		rd(TCPT_OFS_BFC, 32'(TCPT_BFC_RST));
		rd(6'h24, 32'h0, '1, TCPT_RESP_ERR);
		wr(6'h3C, 32'h1, TCPT_RESP_ERR);
		$display("registers test done");
		wr(TCPT_OFS_MOD, 32'hFF);
		wr(TCPT_OFS_CH0V, 32'h80);
		wr(TCPT_OFS_CH0C, 32'h1A);
		wr(TCPT_OFS_CTRL, 32'h0);
		meas(256);
		wr(TCPT_OFS_CH0V, 32'h40);
		meas(256);
		wr(TCPT_OFS_CH0V, 32'hC0);
		meas(256);
		wr(TCPT_OFS_CTRL, 32'h30);
		wr(TCPT_OFS_MOD, 32'h3);
		wr(TCPT_OFS_CH0V, 32'h1);
		for (int ps = 0; ps < 8; ps++)
		begin
			ext_run <= (ps == 7);
			wr(TCPT_OFS_CTRL, 32'(32'h30 | ps));
			wr(TCPT_OFS_CTRL, 32'(ps));
			meas(ps == 7 ? 16 : 4 << ps);
		end
		ext_run <= 1'b0;
		wr(TCPT_OFS_CTRL, 32'h30);
		wr(TCPT_OFS_CH0C, 32'h1E);
		wr(TCPT_OFS_CTRL, 32'h0);
		meas(4);
		$display("pwm test done");
		wr(TCPT_OFS_CTRL, 32'h30);
		wr(TCPT_OFS_CH1C, 32'h10);
		wr(TCPT_OFS_CH0C, 32'h2A);
		wr(TCPT_OFS_CH1V, 32'h2);
		wr(TCPT_OFS_CTRL, 32'h0);
		meas(4);
		$display("linked test done");
		wr(TCPT_OFS_CTRL, 32'h30);
		for (int m = 1; m < 4; m++)
		begin
			drive <= 2'h0;
			wr(TCPT_OFS_CH0C, 32'(32'h40 | (m << 2)));
			v = 16'($urandom) | 16'h1;
			wr(TCPT_OFS_CH0V, 32'(v));
			drive <= 2'h1;
			repeat (3) @(posedge aclk);
			rd(TCPT_OFS_CH0V, m[0] ? 32'h0 : 32'(v));
			v = 16'($urandom) | 16'h1;
			wr(TCPT_OFS_CH0V, 32'(v));
			drive <= 2'h0;
			repeat (3) @(posedge aclk);
			rd(TCPT_OFS_CH0V, m[1] ? 32'h0 : 32'(v));
		end
		rd(TCPT_OFS_CH0C, 32'h80, 32'h80);
		$display("capture test done");
		break_state <= 1'b1;
		wr(TCPT_OFS_CTRL, 32'h0);
		rd(TCPT_OFS_CNT, 32'h0);
		break_state <= 1'b0;
		repeat (20) @(posedge aclk);
		break_state <= 1'b1;
		rd(TCPT_OFS_CTRL, 32'h80, 32'h80);
		wr(TCPT_OFS_CTRL, 32'h0);
		rd(TCPT_OFS_CTRL, 32'h80, 32'h80);
		wr(TCPT_OFS_BFC, 32'h80);
		rd(TCPT_OFS_CTRL, 32'h80, 32'h80);
		wr(TCPT_OFS_CTRL, 32'h20);
		rd(TCPT_OFS_CTRL, 32'h20, 32'hFF);
		break_state <= 1'b0;
		$display("break test done");
		stop_test();
	end
	initial
	begin
		repeat (30000) @(posedge aclk);
		num_errors++;
		stop_test();
	end
endmodule // tb
bind tcpt_timer tcpt_props u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .break_state(break_state),
	.channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
	.channel_pin_oe(channel_pin_oe), .timer_irq(timer_irq));
`default_nettype wire

/* File: verification/tcpt_pin_model.sv */
// Partner: event source on the channel pins, external count clock.
// Assumes the bench sets pin levels and clock bursts.
`timescale 1ns/1ps
`default_nettype none
module tcpt_pin_model (
	input wire logic aclk,
	input wire logic [1:0] drive,
	input wire logic ext_run,
	input wire logic [1:0] channel_pin_out,
	input wire logic [1:0] channel_pin_oe,
	output logic [1:0] channel_pin_in,
	output logic external_count_clock
);
	logic [1:0] div = 2'h0;
	// Clock runs only within bursts
	always @(posedge aclk)
		div <= ext_run ? div + 2'h1 : 2'h0;
	always @(posedge aclk)
		external_count_clock <= ext_run & div[1];
	// Wire level: design drive wins where enabled
	assign channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & drive);
endmodule // tcpt_pin_model
`default_nettype wire

/* File: verification/tcpt_props.sv */
// Checker: bus handshake, pin and interrupt relations of the timer.
// Assumes binding to the timer top with matching port names.
`timescale 1ns/1ps
`default_nettype none
module tcpt_props
	import tcpt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tcpt_pkg::TCPT_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic break_state,
	input wire logic [1:0] channel_pin_in,
	input wire logic [1:0] channel_pin_out,
	input wire logic [1:0] channel_pin_oe,
	input wire logic timer_irq
);
	logic [7:0] c0_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Channel zero control as last written
	always_ff @(posedge aclk)
		if (!aresetn)
			c0_r <= 8'h00;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == TCPT_OFS_CH0C)
			c0_r <= s_axi_wdata[7:0];
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bh: assert property (p_bh) else $error("bvalid dropped");
	property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rh: assert property (p_rh) else $error("read answer dropped");
	property p_ra; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
	a_ra: assert property (p_ra) else $error("no read answer");
	property p_ba; s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
	a_ba: assert property (p_ba) else $error("no write answer");
	property p_ro; $rose(aresetn) |-> !timer_irq && channel_pin_oe == 2'h0; endproperty
	a_ro: assert property (p_ro) else $error("outputs not idle");
	property p_bk; break_state [*4] |-> $stable(channel_pin_out); endproperty
	a_bk: assert property (p_bk) else $error("pin moved in break");
	property p_lk; c0_r[TCPT_CC_MSB] && $past(c0_r[TCPT_CC_MSB], 2) |-> !channel_pin_oe[1]; endproperty
	a_lk: assert property (p_lk) else $error("pin one driven");
	property p_ci;
		c0_r[TCPT_CC_IE] && c0_r[TCPT_CC_ELA] && c0_r[5:4] == 2'h0 && $rose(channel_pin_in[0])
			|-> ##[1:4] timer_irq;
	endproperty
	a_ci: assert property (p_ci) else $error("no capture irq");
	c_bk: cover property (break_state [*4]);
	c_lk: cover property (c0_r[TCPT_CC_MSB] && channel_pin_out[0]);
	c_ir: cover property (timer_irq);
endmodule // tcpt_props
`default_nettype wire
